/* File: src/cces_defs.vh */
/*
 * constants for the condition / error status capture block:
 * register word offsets, bit positions, reset values, timeout figures.
 * assumes a 200 MHz system clock and word-addressed avalon-mm access.
 */
`ifndef CCES_DEFS_VH
`define CCES_DEFS_VH

// register word addresses (avalon address port, one 32-bit word each)
`define CCES_ADDR_COND      3'h0
`define CCES_ADDR_LEVEL     3'h1
`define CCES_ADDR_FAULT     3'h2
`define CCES_ADDR_FCLR      3'h3
`define CCES_ADDR_CHAN      3'h4
`define CCES_ADDR_IRQ_STAT  3'h5
`define CCES_ADDR_IRQ_MASK  3'h6
`define CCES_ADDR_TMO_CTRL  3'h7

// condition bits
`define CCES_C_FLAG   0
`define CCES_C_POS    1
`define CCES_C_NEG    2
`define CCES_C_ZERO   3
`define CCES_C_CARRY  4
`define CCES_C_HIGH   5
`define CCES_C_LOW    6
`define CCES_C_EQUAL  7

// fault bits
`define CCES_F_STORE  0
`define CCES_F_BUS    1
`define CCES_F_TMO4   2
`define CCES_F_FLOW   3
`define CCES_F_PCHK   4
`define CCES_F_TMO    5
`define CCES_F_CHAN   6
`define CCES_F_MAIN   7

// channel fault byte bit driven from here
`define CCES_CH_STEAL 6

// alu operation classes
`define CCES_OP_NONE  2'h0
`define CCES_OP_LOGIC 2'h1
`define CCES_OP_ADD   2'h2
`define CCES_OP_SUB   2'h3

// tmo control bits: 0 arm, 1 kick (restart)
`define CCES_T_ARM    0
`define CCES_T_KICK   1

`define CCES_BYTE_ZERO 8'h00
`define CCES_WORD_ZERO 32'h00000000

// timeouts in their own units, clock in MHz
`define CCES_CLK_MHZ     200
`define CCES_TMO3_SEC    3
`define CCES_TMO4_EXTRA  1
`define CCES_HZ_PER_MHZ  32'h000F4240

// sign position of the alu result
`define CCES_SIGN_BIT 15

`endif

/* File: src/cces_top.v */
/*
 * condition flags, interrupt level capture and processor fault byte
 * for the control processor, with an avalon-mm slave and one irq.
 * assumes ALU result strobes and fault pulses come from logic on CLK;
 * level and halt inputs likewise. the channel gets a steal-fault level.
 */
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cces_defs.vh"

// Behaviour
// - condition flags change only on affecting operations
// - bit 0 flag written only by microcode
// - bit 1 set on positive ALU result
// - bit 2 set on negative ALU result
// - bit 3 set on zero ALU result
// - bit 4 carry out, or no borrow
// - bit 5 high on add/sub positive
// - bit 6 low on add/sub negative
// - bit 7 equal on any zero result
// - level byte captures running level at error
// - faults during steal set channel bit 6
// - fault bit 0 on ECC or storage parity
// - fault bit 1 on system bus parity
// - fault bit 2 after four-second time-out
// - fault bit 3 on data flow parity
// - fault bit 4 processor check sources
// - bit 5 meaning follows bits 6 and 7
// - bit 6 channel check, bit 7 main access
module cces_top #(
    parameter TMO3_CYCLES = `CCES_TMO3_SEC * `CCES_CLK_MHZ * `CCES_HZ_PER_MHZ,
    parameter TMO4_CYCLES = `CCES_TMO4_EXTRA * `CCES_CLK_MHZ * `CCES_HZ_PER_MHZ,
    parameter HWTMO_MS    = 8
)(
    input  wire        CLK,             // 200 MHz system clock
    input  wire        NRST,            // synchronous reset, active low
    input  wire [2:0]  AVS_ADDRESS,     // word address
    input  wire        AVS_READ,        // read request
    input  wire        AVS_WRITE,       // write request
    input  wire [31:0] AVS_WRITEDATA,   // write data
    input  wire [3:0]  AVS_BYTEENABLE,  // byte lanes
    output reg  [31:0] AVS_READDATA,    // read data, valid with waitrequest low
    output reg         AVS_WAITREQUEST, // high until the access is answered
    output reg         IRQ,             // level interrupt, unmasked status set
    input  wire        ALU_VALID,       // one-cycle: an affecting op completed
    input  wire [1:0]  ALU_OP,          // op class: none/logic/add/sub
    input  wire [15:0] ALU_RESULT,      // signed result
    input  wire        ALU_CARRY,       // raw carry out of the top position
    input  wire [2:0]  LEVEL_FIELD,     // running interrupt level, 0 = main
    input  wire        STEAL_ACTIVE,    // cycle steal transfer in progress
    input  wire        ECC_ERR,         // pulse: uncorrectable ECC
    input  wire        STORE_PAR_ERR,   // pulse: control storage parity
    input  wire        BUS_PAR_ERR,     // pulse: system bus parity
    input  wire        FLOW_PAR_ERR,    // pulse: internal data flow parity
    input  wire        CHAN_CHECK,      // pulse: channel check
    input  wire        MAIN_ACC_ERR,    // pulse: main processor access failed
    input  wire        HW_TMO_CHAN,     // pulse: 8 ms hardware tmo by channel
    input  wire        HW_TMO_MAIN,     // pulse: 8 ms hardware tmo by main
    input  wire        CHECK_HALT,      // pulse: check halt instruction
    output reg  [7:0]  FAULT_BYTE,      // processor fault byte
    output reg  [7:0]  COND_FLAGS,      // condition flags
    output reg         CHAN_STEAL_ERR   // sets channel fault byte bit 6
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ANS  = 2'b10;

    reg [7:0]  cond_reg, cond_next;
    reg [7:0]  level_reg;
    reg [7:0]  fault_reg, fault_next;
    reg [7:0]  irq_stat_reg, irq_stat_next;
    reg [7:0]  irq_mask_reg;
    reg [1:0]  tmo_ctrl_reg;
    reg [31:0] tmo_cnt_reg;
    reg        tmo3_hit_reg;
    reg [1:0]  state_reg;
    reg        steal_err_reg;
    reg [31:0] rd_next;

    wire       wr_cycle = (state_reg == ST_IDLE) && AVS_WRITE;
    wire       rd_cycle = (state_reg == ST_IDLE) && AVS_READ;
    wire       lane0    = AVS_BYTEENABLE[0];
    wire [7:0] wbyte    = AVS_WRITEDATA[7:0];
    wire       any_err;
    wire       tmo3_evt;
    wire       tmo4_evt;
    wire [7:0] new_fault;

    // widen a byte into a read word with zero upper bits
    function [31:0] cces_word;
        input [7:0] b;
        begin
            cces_word = {24'h000000, b};
        end
    endfunction

    // register write strobe: idle slave, write, lane 0, matching word.
    // the answer cycle never decodes, so a held request writes once only
    // and a write-one-to-clear cannot be applied twice
    function cces_wr_hit;
        input [2:0] a;
        begin
            cces_wr_hit = wr_cycle && lane0 && (AVS_ADDRESS == a);
        end
    endfunction

    // zero test of an alu result, shared by the zero and equal flags;
    // both bits report the same condition, one as a result class and
    // one as an operand comparison
    function cces_is_zero;
        input [15:0] v;
        begin
            cces_is_zero = ~|v;
        end
    endfunction

    // strictly positive: sign clear and not zero, shared by positive and high
    function cces_is_pos;
        input [15:0] v;
        begin
            cces_is_pos = !v[`CCES_SIGN_BIT] && (|v);
        end
    endfunction

    // microcode loop watchdog: 3 s then 1 s more, restarted by kick.
    // a kick in the same cycle as the expiry wins, so software that is
    // still alive at the last moment is never reported as looping
    wire tmo_armed = tmo_ctrl_reg[`CCES_T_ARM];
    wire tmo_kick  = cces_wr_hit(`CCES_ADDR_TMO_CTRL) && wbyte[`CCES_T_KICK];
    assign tmo3_evt = tmo_armed && !tmo3_hit_reg && !tmo_kick
                      && (tmo_cnt_reg == TMO3_CYCLES - 1);
    assign tmo4_evt = tmo_armed && tmo3_hit_reg && !tmo_kick
                      && (tmo_cnt_reg == TMO4_CYCLES - 1);
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            tmo_cnt_reg  <= `CCES_WORD_ZERO;
            tmo3_hit_reg <= 1'b0;
        end
        else if (!tmo_armed || tmo_kick)
        begin
            tmo_cnt_reg  <= `CCES_WORD_ZERO;
            tmo3_hit_reg <= 1'b0;
        end
        else if (tmo3_evt || tmo4_evt)
        begin
            tmo_cnt_reg  <= `CCES_WORD_ZERO;
            tmo3_hit_reg <= 1'b1; // stays armed for the extra second
        end
        else
        begin
            tmo_cnt_reg <= tmo_cnt_reg + 32'h00000001;
        end
    end

    // gather this cycle's fault events into a byte
    assign new_fault[`CCES_F_STORE] = ECC_ERR | STORE_PAR_ERR;
    assign new_fault[`CCES_F_BUS]   = BUS_PAR_ERR;
    assign new_fault[`CCES_F_TMO4]  = tmo4_evt;
    assign new_fault[`CCES_F_FLOW]  = FLOW_PAR_ERR;
    assign new_fault[`CCES_F_CHAN]  = CHAN_CHECK | HW_TMO_CHAN;
    assign new_fault[`CCES_F_MAIN]  = MAIN_ACC_ERR | HW_TMO_MAIN;
    // bit 5 is the 3 s tmo alone, or the 8 ms tmo with bit 6 or 7 naming the unit
    assign new_fault[`CCES_F_TMO]   = tmo3_evt | HW_TMO_CHAN | HW_TMO_MAIN;
    // processor-side errors; any of them is also a processor check
    wire proc_err = ECC_ERR | STORE_PAR_ERR | BUS_PAR_ERR | FLOW_PAR_ERR
                    | MAIN_ACC_ERR;
    // channel-side errors; the hardware time-outs report through bit 5
    wire chan_err = CHAN_CHECK;
    assign new_fault[`CCES_F_PCHK]  = proc_err | chan_err | tmo4_evt
                                      | CHECK_HALT;
    assign any_err = |new_fault;

    // fault byte: sticky, write-one-to-clear via the clear word; set wins
    always @*
    begin
        fault_next = fault_reg;
        if (cces_wr_hit(`CCES_ADDR_FCLR))
        begin
            fault_next = fault_next & ~wbyte;
        end
        fault_next = fault_next | new_fault;
    end

    // only real operations touch the flags; a none-class strobe is ignored
    wire alu_hit    = ALU_VALID && (ALU_OP != `CCES_OP_NONE);
    wire alu_addsub = (ALU_OP == `CCES_OP_ADD) || (ALU_OP == `CCES_OP_SUB);

    // condition flags: alu strobe updates bits 1..7, software owns bit 0
    always @*
    begin
        cond_next = cond_reg;
        if (cces_wr_hit(`CCES_ADDR_COND))
        begin
            cond_next[`CCES_C_FLAG] = wbyte[`CCES_C_FLAG];
        end
        if (alu_hit)
        begin
            cond_next[`CCES_C_POS]   = cces_is_pos(ALU_RESULT);
            cond_next[`CCES_C_NEG]   = ALU_RESULT[`CCES_SIGN_BIT];
            cond_next[`CCES_C_ZERO]  = cces_is_zero(ALU_RESULT);
            cond_next[`CCES_C_EQUAL] = cces_is_zero(ALU_RESULT);
            // subtract carry means no borrow, same carry polarity as add
            cond_next[`CCES_C_CARRY] = alu_addsub && ALU_CARRY;
            cond_next[`CCES_C_HIGH]  = alu_addsub && cces_is_pos(ALU_RESULT);
            cond_next[`CCES_C_LOW]   = alu_addsub && ALU_RESULT[`CCES_SIGN_BIT];
        end
    end

    // interrupt status: sticky per fault bit, cleared by reading it
    always @*
    begin
        irq_stat_next = irq_stat_reg;
        if (rd_cycle && (AVS_ADDRESS == `CCES_ADDR_IRQ_STAT))
        begin
            irq_stat_next = `CCES_BYTE_ZERO;
        end
        irq_stat_next = irq_stat_next | new_fault; // event in same cycle survives
    end

    // cond, fault and irq status share one reset and load every cycle
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            cond_reg     <= `CCES_BYTE_ZERO;
            fault_reg    <= `CCES_BYTE_ZERO;
            irq_stat_reg <= `CCES_BYTE_ZERO;
        end
        else
        begin
            cond_reg     <= cond_next;
            fault_reg    <= fault_next;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // level byte: the last error wins, so a burst logs the latest level
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            level_reg <= `CCES_BYTE_ZERO;
        end
        else if (any_err)
        begin
            level_reg <= {5'h00, LEVEL_FIELD};
        end
    end

    // channel bit 6 holds until the whole fault byte is clear; set wins
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            steal_err_reg <= 1'b0;
        end
        else if (any_err && STEAL_ACTIVE)
        begin
            steal_err_reg <= 1'b1;
        end
        else if (fault_next == `CCES_BYTE_ZERO)
        begin
            steal_err_reg <= 1'b0;
        end
    end

    // interrupt mask, same layout as the status byte
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            irq_mask_reg <= `CCES_BYTE_ZERO;
        end
        else if (cces_wr_hit(`CCES_ADDR_IRQ_MASK))
        begin
            irq_mask_reg <= wbyte;
        end
    end

    // watchdog control: only arm is stored, kick acts as a strobe
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            tmo_ctrl_reg <= 2'h0;
        end
        else if (cces_wr_hit(`CCES_ADDR_TMO_CTRL))
        begin
            tmo_ctrl_reg <= {1'b0, wbyte[`CCES_T_ARM]};
        end
    end

    // read mux, decoded from the live address; the handshake registers it
    // in the taking cycle, so a read never sees a half-updated byte.
    // unmapped words cannot occur: all eight addresses are in use; the clear word has no read case and reads zero
    always @*
    begin
        case (AVS_ADDRESS)
            `CCES_ADDR_COND:     rd_next = cces_word(cond_reg);
            `CCES_ADDR_LEVEL:    rd_next = cces_word(level_reg);
            `CCES_ADDR_FAULT:    rd_next = cces_word(fault_reg);
            `CCES_ADDR_CHAN:     rd_next = {31'h00000000, steal_err_reg};
            `CCES_ADDR_IRQ_STAT: rd_next = cces_word(irq_stat_reg);
            `CCES_ADDR_IRQ_MASK: rd_next = cces_word(irq_mask_reg);
            `CCES_ADDR_TMO_CTRL: rd_next = {30'h00000000, tmo3_hit_reg, tmo_ctrl_reg[0]};
            default:             rd_next = `CCES_WORD_ZERO;
        endcase
    end

    // bus handshake: take in idle, answer next cycle with waitrequest low.
    // one wait state keeps readdata registered, at the cost of throughput.
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            state_reg       <= ST_IDLE;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA    <= `CCES_WORD_ZERO;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (AVS_READ || AVS_WRITE)
                    begin
                        state_reg       <= ST_ANS;
                        AVS_WAITREQUEST <= 1'b0;
                        AVS_READDATA    <= AVS_READ ? rd_next : `CCES_WORD_ZERO;
                    end
                end
                ST_ANS:
                begin
                    state_reg       <= ST_IDLE;
                    AVS_WAITREQUEST <= 1'b1;
                end
                default:
                begin
                    state_reg       <= ST_IDLE;
                    AVS_WAITREQUEST <= 1'b1;
                end
            endcase
        end
    end

    // registered copies to outputs; every output leaves a flip-flop,
    // which costs a cycle of latency against the internal registers
    // but keeps the pin timing independent of the decode logic
    always @(posedge CLK)
    begin
        if (!NRST)
        begin
            IRQ            <= 1'b0;
            FAULT_BYTE     <= `CCES_BYTE_ZERO;
            COND_FLAGS     <= `CCES_BYTE_ZERO;
            CHAN_STEAL_ERR <= 1'b0;
        end
        else
        begin
            IRQ            <= |(irq_stat_reg & irq_mask_reg);
            FAULT_BYTE     <= fault_reg;
            COND_FLAGS     <= cond_reg;
            CHAN_STEAL_ERR <= steal_err_reg;
        end
    end
endmodule
`default_nettype wire

/* File: verif/cces_top_asserts.sv */
/*
 * port-level assertions for the condition / fault status block.
 * assumes a bind onto cces_top, single clock, sync active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module cces_top_asserts (
    input wire logic        CLK,            // system clock
    input wire logic        NRST,           // sync reset, active low
    input wire logic [2:0]  AVS_ADDRESS,    // word address
    input wire logic        AVS_WRITE,      // write request
    input wire logic        ALU_VALID,      // op completed
    input wire logic [1:0]  ALU_OP,         // op class
    input wire logic [15:0] ALU_RESULT,     // signed result
    input wire logic        STEAL_ACTIVE,   // cycle steal running
    input wire logic        ECC_ERR,        // storage fault pulse
    input wire logic        BUS_PAR_ERR,    // bus parity pulse
    input wire logic        HW_TMO_CHAN,    // channel hw time-out pulse
    input wire logic [7:0]  FAULT_BYTE,     // fault byte
    input wire logic [7:0]  COND_FLAGS,     // condition flags
    input wire logic        CHAN_STEAL_ERR  // steal fault to channel
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    // outputs trail their cause by two edges, so every check looks two cycles on
    wire cond_wr = AVS_WRITE && AVS_ADDRESS == 3'h0;
    wire clr_wr  = AVS_WRITE && AVS_ADDRESS == 3'h3;
    wire alu_on  = ALU_VALID && ALU_OP != 2'h0;

    zero_equal_a: assert property (
        alu_on && ALU_RESULT == 16'h0000 |-> ##2 COND_FLAGS[3] && COND_FLAGS[7])
        else $error("zero result not flagged");
    result_sign_a: assert property (
        alu_on && ALU_RESULT != 16'h0000
        |-> ##2 COND_FLAGS[2:1] == {$past(ALU_RESULT[15], 2), !$past(ALU_RESULT[15], 2)})
        else $error("sign flags wrong");
    cond_hold_a: assert property (
        !ALU_VALID && !cond_wr |-> ##2 $stable(COND_FLAGS))
        else $error("condition flags moved without cause");
    flag_owner_a: assert property (
        !cond_wr |-> ##2 $stable(COND_FLAGS[0]))
        else $error("flag bit moved without a write");
    fault_sticky_a: assert property (
        !clr_wr |-> ##2 (FAULT_BYTE & $past(FAULT_BYTE)) == $past(FAULT_BYTE))
        else $error("fault bit dropped");
    bus_check_a: assert property (
        BUS_PAR_ERR |-> ##2 FAULT_BYTE[1] && FAULT_BYTE[4])
        else $error("bus parity not recorded");
    hw_timeout_a: assert property (
        HW_TMO_CHAN |-> ##2 FAULT_BYTE[6:5] == 2'b11)
        else $error("channel time-out not recorded");
    steal_fault_a: assert property (
        STEAL_ACTIVE && (ECC_ERR || BUS_PAR_ERR) |-> ##2 CHAN_STEAL_ERR && FAULT_BYTE[0] | FAULT_BYTE[1])
        else $error("steal fault not passed on");

    alu_zero_c: cover property (alu_on && ALU_RESULT == 16'h0000);
    steal_c: cover property (STEAL_ACTIVE && BUS_PAR_ERR);
    clear_c: cover property (clr_wr && FAULT_BYTE != 8'h00);
endmodule

bind cces_top cces_top_asserts cces_top_asserts_inst (
    .CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
    .ALU_VALID(ALU_VALID), .ALU_OP(ALU_OP), .ALU_RESULT(ALU_RESULT),
    .STEAL_ACTIVE(STEAL_ACTIVE), .ECC_ERR(ECC_ERR), .BUS_PAR_ERR(BUS_PAR_ERR),
    .HW_TMO_CHAN(HW_TMO_CHAN), .FAULT_BYTE(FAULT_BYTE), .COND_FLAGS(COND_FLAGS),
    .CHAN_STEAL_ERR(CHAN_STEAL_ERR));
`default_nettype wire

/* File: verif/tb.sv */
/*
 * self-checking bench for the condition / fault status block.
 * assumes cces_top with short time-out parameters and one 200 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, valid = 0, carry = 0, steal = 0, c, f;
    logic [2:0] addr = 0, lvl = 0;
    logic [1:0] op = 0, o;
    logic [15:0] res = 0, r, note;
    logic [7:0] wdat = 0, e;
    logic [8:0] ev = 0;
    logic [7:0] fx [9] = '{8'h11, 8'h11, 8'h12, 8'h18, 8'h50, 8'h80, 8'h60, 8'hA0, 8'h10};
    wire [31:0] rdata;
    wire wait_r, irq, cse;
    wire [7:0] fb, cf;
    int err_total = 0, total_checks = 0;
    logic [15:0] q [$];

    cces_top #(.TMO3_CYCLES(20), .TMO4_CYCLES(10)) cces_top_inst (
        .CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA({24'h000000, wdat}), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_r), .IRQ(irq), .ALU_VALID(valid), .ALU_OP(op),
        .ALU_RESULT(res), .ALU_CARRY(carry), .LEVEL_FIELD(lvl), .STEAL_ACTIVE(steal),
        .ECC_ERR(ev[0]), .STORE_PAR_ERR(ev[1]), .BUS_PAR_ERR(ev[2]), .FLOW_PAR_ERR(ev[3]),
        .CHAN_CHECK(ev[4]), .MAIN_ACC_ERR(ev[5]), .HW_TMO_CHAN(ev[6]), .HW_TMO_MAIN(ev[7]),
        .CHECK_HALT(ev[8]), .FAULT_BYTE(fb), .COND_FLAGS(cf), .CHAN_STEAL_ERR(cse));

    // 200 MHz clock
    initial forever #2.5 clk = ~clk;

    // scoreboard: each answered read takes the oldest {mask, value} note
    always @(posedge clk)
    begin
        if (rd && wait_r === 1'b0)
        begin
            note = q.pop_front();
            total_checks++;
            if ((rdata[7:0] & note[15:8]) !== (note[7:0] & note[15:8]))
            begin
                err_total++;
                $display("ERROR %0t read %h want %h", $time, rdata[7:0], note[7:0]);
            end
        end
    end

    // request held until waitrequest is seen low; the watchdog bounds the wait
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdat <= d;
        do @(posedge clk); while (wait_r !== 1'b0);
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [2:0] a, input logic [7:0] v, input logic [7:0] m);
        q.push_back({m, v});
        bus(0, a, 8'h00);
    endtask

    task automatic chk(input logic v, input logic x);
        total_checks++;
        if (v !== x)
        begin
            err_total++;
            $display("ERROR %0t level %b", $time, v);
        end
    endtask

    // flags from the op class, result, raw carry and the microcode flag
    function automatic logic [7:0] cexp(input logic [1:0] oc, input logic [15:0] rv,
                                        input logic cv, input logic fv);
        logic z;
        z = rv == 16'h0000;
        return {z, oc[1] & rv[15], oc[1] & !rv[15] & !z, oc[1] & cv, z, rv[15],
                !rv[15] & !z, fv};
    endfunction

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // hang guard, well beyond the roughly five hundred cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end

    // main sequence
    initial
    begin
        void'($urandom(17));
        repeat (6) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        for (int a = 0; a < 3; a++)
            rdc(a[2:0], 8'h00, 8'hFF);
        $display("test reset done");
        // boundary results first, then random ones; flag set by write from i = 6
        for (int i = 0; i < 12; i++)
        begin
            o = 2'(1 + i % 3);
            r = i < 3 ? 16'h0000 : i < 6 ? 16'h8000 : i < 8 ? 16'h7FFF : 16'($urandom);
            c = 1'($urandom);
            f = i > 5;
            if (i == 6)
                bus(1, 3'h0, 8'hFF);
            op <= o;
            res <= r;
            carry <= c;
            valid <= 1;
            @(posedge clk);
            valid <= 0;
            e = cexp(o, r, c, f);
            rdc(3'h0, e, 8'hFF);
            rdc(3'h0, e, 8'hFF);
        end
        chk(cf[0], 1'b1);
        $display("test alu done");
        // each fault source alone, level and steal varied, irq masked then open
        for (int k = 0; k < 9; k++)
        begin
            bus(1, 3'h6, 8'h00);
            lvl <= 3'(k % 6);
            steal <= k[0];
            ev <= 9'(1 << k);
            @(posedge clk);
            ev <= 0;
            repeat (3) @(posedge clk);
            chk(irq, 1'b0);
            bus(1, 3'h6, 8'hFF);
            repeat (2) @(posedge clk);
            chk(irq, 1'b1);
            chk(cse, k[0]);
            chk((fb & 8'hEF) == (fx[k] & 8'hEF), 1'b1);
            rdc(3'h2, fx[k], k > 4 && k < 8 ? 8'hEF : 8'hFF);
            rdc(3'h2, fx[k], 8'hEF);
            rdc(3'h1, 8'(k % 6), 8'hFF);
            rdc(3'h4, {7'h00, k[0]}, 8'h01);
            rdc(3'h5, fx[k], 8'hEF);
            repeat (3) @(posedge clk);
            chk(irq, 1'b0);
            bus(1, 3'h3, 8'hFF);
            rdc(3'h2, 8'h00, 8'hFF);
        end
        $display("test faults done");
        // kicks inside the window keep the timer quiet; then let it run out
        bus(1, 3'h7, 8'h01);
        repeat (4)
        begin
            repeat (8) @(posedge clk);
            bus(1, 3'h7, 8'h03);
        end
        rdc(3'h2, 8'h00, 8'hFF);
        repeat (22) @(posedge clk);
        rdc(3'h2, 8'h20, 8'hEF);
        repeat (15) @(posedge clk);
        rdc(3'h2, 8'h34, 8'hFF);
        bus(1, 3'h7, 8'h00);
        $display("test timer done");
        test_done();
    end
endmodule
`default_nettype wire
